// ==== pmd_top.sv ====
// Program memory map decoder: config load, address routing, APB regs.
`timescale 1ns/1ps
module pmd_top (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic pkg_80pin,
    input wire pmd_pkg::pmd_req_t req,
    output pmd_pkg::pmd_rsp_t rsp,
    output logic req_ready,
    input wire logic irq_high,
    input wire logic irq_low,
    output logic [20:0] vec_addr,
    output logic vec_load,
    output logic flash_rd,
    output logic [19:0] flash_addr,
    input wire logic [15:0] flash_rdata,
    output pmd_pkg::pmd_xbus_t xbus,
    input wire logic ext_ack,
    input wire logic [15:0] ext_rdata,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    // ==========================================================
    // Decode helpers
    function automatic logic in_flash(input logic [20:0] a);
        return a < pmd_pkg::FLASH_BYTES;
    endfunction

    function automatic logic ext_on(input logic p80, input logic [7:0] c);
        logic [1:0] m;
        m = c[pmd_pkg::MODE_HI:pmd_pkg::MODE_LO];
        return p80 && (m != pmd_pkg::MODE_ON_CHIP);
    endfunction

    function automatic logic [19:0] ext_map(input logic [20:0] a,
                                            input logic [7:0] c);
        logic [20:0] base;
        logic [19:0] mask;
        // Without shifting, the request address goes to the bus unchanged before the mode mask
        base = c[pmd_pkg::SHIFT_BIT] ? a - pmd_pkg::FLASH_BYTES : a;
        unique case (c[pmd_pkg::MODE_HI:pmd_pkg::MODE_LO])
            pmd_pkg::MODE_EXT_A12: mask = pmd_pkg::MASK_A12;
            pmd_pkg::MODE_EXT_A16: mask = pmd_pkg::MASK_A16;
            default: mask = pmd_pkg::MASK_A20;
        endcase
        return base[19:0] & mask;
    endfunction

    // ==========================================================
    // State
    pmd_pkg::pmd_state_t st_reg;
    pmd_pkg::pmd_state_t st_next;
    logic apb_setup;
    logic apb_done;

    assign apb_setup = psel && penable && !st_reg.pready;
    assign apb_done = psel && penable && st_reg.pready;

    always_comb begin
        st_next = st_reg;
        st_next.fl_rd = 1'b0;
        st_next.fl_pend = st_reg.fl_rd;
        st_next.rsp.valid = 1'b0;
        st_next.vec_load = 1'b0;
        st_next.pready = apb_setup;
        st_next.pslverr = 1'b0;
        unique case (st_reg.phase)
            pmd_pkg::PH_LOAD: begin
                // Strap is caught by a clocked process, frozen once running
                st_next.pkg80 = pkg_80pin;
                if (st_reg.fl_pend) begin
                    st_next.cfg[{st_reg.ld_cnt, 1'b0}] = flash_rdata[7:0];
                    st_next.cfg[{st_reg.ld_cnt, 1'b1}] = flash_rdata[15:8];
                    st_next.ld_cnt = st_reg.ld_cnt + pmd_pkg::LD_STEP;
                    if (st_reg.ld_cnt == pmd_pkg::CFG_LAST_WORD) begin
                        // Fourth word is never read
                        st_next.ebc = flash_rdata[7:0] & pmd_pkg::EBC_IMPL_MASK;
                        st_next.phase = pmd_pkg::PH_RUN;
                        st_next.vec_addr = pmd_pkg::VEC_RESET;
                        st_next.vec_load = 1'b1;
                    end
                end else if (!st_reg.fl_rd) begin
                    st_next.fl_rd = 1'b1;
                    st_next.fl_addr = pmd_pkg::CFG_BASE[20:1]
                        + 20'(st_reg.ld_cnt);
                end
            end
            pmd_pkg::PH_RUN: begin
                unique case (st_reg.route)
                    pmd_pkg::RT_IDLE: begin
                        if (req.valid && st_reg.ready) begin
                            if (in_flash(req.addr)) begin
                                st_next.route = pmd_pkg::RT_FLASH;
                                st_next.fl_rd = 1'b1;
                                st_next.fl_addr = req.addr[20:1];
                            end else if (ext_on(st_reg.pkg80, st_reg.ebc)) begin
                                st_next.route = pmd_pkg::RT_EXT;
                                st_next.xbus.rd = 1'b1;
                                st_next.xbus.addr = ext_map(req.addr,
                                                            st_reg.ebc);
                            end else begin
                                st_next.route = pmd_pkg::RT_ZERO;
                            end
                        end
                    end
                    pmd_pkg::RT_FLASH: begin
                        if (st_reg.fl_pend) begin
                            st_next.rsp.valid = 1'b1;
                            st_next.rsp.data = flash_rdata;
                            st_next.route = pmd_pkg::RT_IDLE;
                        end
                    end
                    pmd_pkg::RT_EXT: begin
                        // Bus request holds until the bus side acknowledges
                        if (ext_ack) begin
                            st_next.xbus.rd = 1'b0;
                            st_next.rsp.valid = 1'b1;
                            st_next.rsp.data = ext_rdata;
                            st_next.route = pmd_pkg::RT_IDLE;
                        end
                    end
                    pmd_pkg::RT_ZERO: begin
                        st_next.rsp.valid = 1'b1;
                        st_next.rsp.data = pmd_pkg::NOP_WORD;
                        st_next.route = pmd_pkg::RT_IDLE;
                    end
                endcase
                if (irq_high) begin
                    st_next.vec_addr = pmd_pkg::VEC_HIGH;
                    st_next.vec_load = 1'b1;
                end else if (irq_low) begin
                    st_next.vec_addr = pmd_pkg::VEC_LOW;
                    st_next.vec_load = 1'b1;
                end
            end
        endcase
        // Program port has no tie to the data RAM side
        st_next.ready = (st_next.phase == pmd_pkg::PH_RUN)
            && (st_next.route == pmd_pkg::RT_IDLE);
        // ======================================================
        // Register bus
        if (apb_setup) begin
            st_next.prdata = '0;
            unique case (paddr)
                pmd_pkg::OFS_EBC: st_next.prdata[7:0] = st_reg.ebc;
                pmd_pkg::OFS_MEMCTL: st_next.prdata[7:0] = st_reg.memctl;
                pmd_pkg::OFS_STATUS: begin
                    st_next.prdata[pmd_pkg::STAT_RUN] =
                        st_reg.phase == pmd_pkg::PH_RUN;
                    st_next.prdata[pmd_pkg::STAT_PKG80] = st_reg.pkg80;
                    st_next.prdata[pmd_pkg::STAT_EXT] = st_reg.xbus.en;
                    st_next.prdata[pmd_pkg::STAT_LOCK] = st_reg.ebc_locked;
                end
                pmd_pkg::OFS_CFG1: st_next.prdata[15:0] =
                    {st_reg.cfg[1], st_reg.cfg[0]};
                pmd_pkg::OFS_CFG2: st_next.prdata[15:0] =
                    {st_reg.cfg[3], st_reg.cfg[2]};
                pmd_pkg::OFS_CFG3: st_next.prdata[15:0] =
                    {st_reg.cfg[5], st_reg.cfg[4]};
                default: st_next.pslverr = 1'b1;
            endcase
        end
        if (apb_done && pwrite) begin
            unique case (paddr)
                pmd_pkg::OFS_EBC: begin
                    // Write-once after load; later writes are dropped
                    if (!st_reg.ebc_locked
                            && st_reg.phase == pmd_pkg::PH_RUN) begin
                        st_next.ebc = pwdata[7:0] & pmd_pkg::EBC_IMPL_MASK;
                        st_next.ebc_locked = 1'b1;
                    end
                end
                pmd_pkg::OFS_MEMCTL: st_next.memctl = pwdata[7:0];
                default: begin
                end
            endcase
        end
        // ======================================================
        // Effective external bus settings
        st_next.xbus.en = ext_on(st_next.pkg80, st_next.ebc);
        st_next.xbus.wide = st_next.pkg80
            && st_next.ebc[pmd_pkg::WIDTH_BIT];
        st_next.xbus.wait_en = st_next.pkg80
            && !st_next.ebc[pmd_pkg::WAIT_BIT];
        st_next.xbus.wait_cnt = st_next.xbus.wait_en
            ? st_next.memctl[pmd_pkg::WS_HI:pmd_pkg::WS_LO]
            : pmd_pkg::WS_NONE;
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign rsp = st_reg.rsp;
    assign req_ready = st_reg.ready;
    assign vec_addr = st_reg.vec_addr;
    assign vec_load = st_reg.vec_load;
    assign flash_rd = st_reg.fl_rd;
    assign flash_addr = st_reg.fl_addr;
    assign xbus = st_reg.xbus;
    assign prdata = st_reg.prdata;
    assign pready = st_reg.pready;
    assign pslverr = st_reg.pslverr;

    // ==========================================================
    // Checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    logic acc_take;
    assign acc_take = req.valid && st_reg.ready;

    unimpl_zero_a: assert property (
        acc_take && !in_flash(req.addr) && !ext_on(st_reg.pkg80, st_reg.ebc)
        |-> ##2 rsp.valid && rsp.data == pmd_pkg::NOP_WORD && !xbus.rd)
        else $error("unimplemented access did not return zero");
    flash_route_a: assert property (
        acc_take && in_flash(req.addr)
        |=> flash_rd && flash_addr == $past(req.addr[20:1]) ##2 rsp.valid)
        else $error("flash access misrouted");
    ext_route_a: assert property (
        acc_take && !in_flash(req.addr) && ext_on(st_reg.pkg80, st_reg.ebc)
        |=> xbus.rd && !flash_rd
            && xbus.addr == ext_map($past(req.addr), $past(st_reg.ebc)))
        else $error("external access misrouted");
    boot_vector_a: assert property (
        $rose(st_reg.phase == pmd_pkg::PH_RUN)
        |-> vec_load && vec_addr == pmd_pkg::VEC_RESET)
        else $error("no restart at reset vector");
    irq_vector_a: assert property (
        st_reg.phase == pmd_pkg::PH_RUN && (irq_high || irq_low)
        |=> vec_load && vec_addr == ($past(irq_high)
            ? pmd_pkg::VEC_HIGH : pmd_pkg::VEC_LOW))
        else $error("wrong interrupt vector");
    load_first_a: assert property (
        st_reg.phase == pmd_pkg::PH_LOAD |-> !req_ready && !rsp.valid)
        else $error("fetch taken during config load");
    cfg_area_a: assert property (
        st_reg.phase == pmd_pkg::PH_LOAD && flash_rd
        |-> flash_addr >= pmd_pkg::CFG_BASE[20:1]
            && flash_addr < pmd_pkg::CFG_BASE[20:1] + 20'(3))
        else $error("config load outside used words");
    small_pkg_a: assert property (
        st_reg.phase == pmd_pkg::PH_RUN && !st_reg.pkg80
        |-> !xbus.en && !xbus.rd && !xbus.wide && !xbus.wait_en)
        else $error("bus active on small package");
    wait_sel_a: assert property (
        xbus.wait_en |-> xbus.wait_cnt
            == st_reg.memctl[pmd_pkg::WS_HI:pmd_pkg::WS_LO])
        else $error("wait count not from control field");

    // ==========================================================
    // Load and bus settings
    load_order_a: assert property (
        st_reg.phase == pmd_pkg::PH_LOAD && flash_rd
        |-> flash_addr == pmd_pkg::CFG_BASE[20:1] + 20'(st_reg.ld_cnt))
        else $error("config words read out of order");
    three_words_a: assert property (
        st_reg.phase == pmd_pkg::PH_RUN
        |-> st_reg.ld_cnt == pmd_pkg::CFG_LAST_WORD + pmd_pkg::LD_STEP)
        else $error("config load count wrong");
    boot_ready_a: assert property (
        $rose(st_reg.phase == pmd_pkg::PH_RUN) |-> req_ready)
        else $error("fetch port not ready after load");
    pkg_frozen_a: assert property (
        st_reg.phase == pmd_pkg::PH_RUN |=> $stable(st_reg.pkg80))
        else $error("package strap changed while running");
    wait_off_a: assert property (
        !xbus.wait_en |-> xbus.wait_cnt == pmd_pkg::WS_NONE)
        else $error("wait count set with waits disabled");
    wide_sel_a: assert property (
        st_reg.phase == pmd_pkg::PH_RUN
        |-> xbus.wide == (st_reg.pkg80 && st_reg.ebc[pmd_pkg::WIDTH_BIT]))
        else $error("data width select wrong");

    // ==========================================================
    // Routing and external address
    // Width checks assume software does not rewrite the mode mid-access
    mc_bus_idle_a: assert property (
        acc_take && !ext_on(st_reg.pkg80, st_reg.ebc)
        |=> !xbus.rd ##1 !xbus.rd)
        else $error("bus read outside extended mode");
    flash_no_bus_a: assert property (
        st_reg.route == pmd_pkg::RT_FLASH |-> !xbus.rd)
        else $error("bus read during flash access");
    ext_hold_a: assert property (
        xbus.rd && !ext_ack |=> xbus.rd && $stable(xbus.addr))
        else $error("bus request dropped before acknowledge");
    a12_width_a: assert property (
        xbus.rd && st_reg.ebc[pmd_pkg::MODE_HI:pmd_pkg::MODE_LO]
            == pmd_pkg::MODE_EXT_A12 |-> xbus.addr[19:12] == '0)
        else $error("address wider than 12 bits");
    a16_width_a: assert property (
        xbus.rd && st_reg.ebc[pmd_pkg::MODE_HI:pmd_pkg::MODE_LO]
            == pmd_pkg::MODE_EXT_A16 |-> xbus.addr[19:16] == '0)
        else $error("address wider than 16 bits");
    shift_base_a: assert property (
        acc_take && req.addr == pmd_pkg::FLASH_BYTES
            && st_reg.ebc[pmd_pkg::SHIFT_BIT]
            && ext_on(st_reg.pkg80, st_reg.ebc)
        |=> xbus.rd && xbus.addr == '0)
        else $error("shifted bus space does not start at zero");
    no_shift_a: assert property (
        acc_take && !in_flash(req.addr) && ext_on(st_reg.pkg80, st_reg.ebc)
            && !st_reg.ebc[pmd_pkg::SHIFT_BIT]
        |=> xbus.addr[11:0] == $past(req.addr[11:0]))
        else $error("unshifted bus address differs");
endmodule

// ==== pmd_pkg.sv ====
// Constants and types for the program memory map decoder.
package pmd_pkg;
    // ==========================================================
    // Address map
    localparam logic [20:0] FLASH_BYTES = 21'h020000;
    localparam logic [20:0] CFG_BYTES = 21'h000008;
    localparam logic [20:0] CFG_BASE = FLASH_BYTES - CFG_BYTES;
    localparam logic [1:0] CFG_LAST_WORD = 2'h2;
    localparam logic [1:0] LD_STEP = 2'h1;
    localparam logic [20:0] VEC_RESET = 21'h000000;
    localparam logic [20:0] VEC_HIGH = 21'h000008;
    localparam logic [20:0] VEC_LOW = 21'h000018;
    localparam logic [15:0] NOP_WORD = 16'h0000;
    // ==========================================================
    // External bus configuration fields
    localparam int unsigned WAIT_BIT = 7;
    localparam int unsigned WIDTH_BIT = 6;
    localparam int unsigned MODE_HI = 5;
    localparam int unsigned MODE_LO = 4;
    localparam int unsigned SHIFT_BIT = 3;
    localparam logic [7:0] EBC_IMPL_MASK = 8'hF8;
    localparam logic [1:0] MODE_ON_CHIP = 2'h3;
    localparam logic [1:0] MODE_EXT_A12 = 2'h2;
    localparam logic [1:0] MODE_EXT_A16 = 2'h1;
    localparam logic [19:0] MASK_A12 = 20'h00FFF;
    localparam logic [19:0] MASK_A16 = 20'h0FFFF;
    localparam logic [19:0] MASK_A20 = 20'hFFFFF;
    localparam int unsigned WS_HI = 5;
    localparam int unsigned WS_LO = 4;
    localparam logic [1:0] WS_NONE = 2'h0;
    // ==========================================================
    // Register offsets and status bits
    localparam logic [11:0] OFS_EBC = 12'h000;
    localparam logic [11:0] OFS_MEMCTL = 12'h004;
    localparam logic [11:0] OFS_STATUS = 12'h008;
    localparam logic [11:0] OFS_CFG1 = 12'h00C;
    localparam logic [11:0] OFS_CFG2 = 12'h010;
    localparam logic [11:0] OFS_CFG3 = 12'h014;
    localparam int unsigned STAT_RUN = 0;
    localparam int unsigned STAT_PKG80 = 1;
    localparam int unsigned STAT_EXT = 2;
    localparam int unsigned STAT_LOCK = 3;
    // ==========================================================
    // Types
    typedef enum logic {PH_LOAD, PH_RUN} pmd_phase_t;
    typedef enum logic [1:0] {RT_IDLE, RT_FLASH, RT_EXT, RT_ZERO} pmd_route_t;
    typedef struct packed {
        logic valid;
        logic [20:0] addr;
    } pmd_req_t;
    typedef struct packed {
        logic valid;
        logic [15:0] data;
    } pmd_rsp_t;
    typedef struct packed {
        logic en;
        logic rd;
        logic [19:0] addr;
        logic wide;
        logic wait_en;
        logic [1:0] wait_cnt;
    } pmd_xbus_t;
    typedef struct packed {
        pmd_phase_t phase;
        logic [1:0] ld_cnt;
        logic pkg80;
        logic [5:0][7:0] cfg;
        logic [7:0] ebc;
        logic ebc_locked;
        logic [7:0] memctl;
        pmd_route_t route;
        logic fl_rd;
        logic fl_pend;
        logic [19:0] fl_addr;
        logic ready;
        pmd_rsp_t rsp;
        pmd_xbus_t xbus;
        logic [20:0] vec_addr;
        logic vec_load;
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
    } pmd_state_t;
endpackage

// ==== pmd_mem_model.sv ====
// Flash and external program memory models facing the decoder.
`timescale 1ns/1ps
module pmd_mem_model (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic flash_rd,
    input wire logic [19:0] flash_addr,
    output logic [15:0] flash_rdata,
    input wire pmd_pkg::pmd_xbus_t xbus,
    output logic ext_ack,
    output logic [15:0] ext_rdata,
    input wire logic [7:0] cfg_byte,
    input wire logic [3:0] ack_delay
);
    logic [3:0] wait_cnt;
    // ==========================================================
    // Flash: data only valid in the cycle after the read strobe
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            flash_rdata <= 16'h0F0F;
        end else if (flash_rd && flash_addr == 20'h0FFFE) begin
            flash_rdata <= {8'h5C, cfg_byte};
        end else if (flash_rd) begin
            flash_rdata <= flash_addr[15:0] ^ 16'h3C5A;
        end else begin
            // Stale data flips, so a late capture cannot pass
            flash_rdata <= ~flash_rdata;
        end
    end
    // ==========================================================
    // External memory: acknowledge after a programmable delay
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ext_ack <= 1'b0;
            wait_cnt <= 4'h0;
            ext_rdata <= 16'hF0F0;
        end else if (ext_ack) begin
            ext_ack <= 1'b0;
            wait_cnt <= 4'h0;
            ext_rdata <= ~ext_rdata;
        end else if (xbus.rd && wait_cnt == ack_delay) begin
            ext_ack <= 1'b1;
            ext_rdata <= xbus.addr[15:0] ^ 16'h9A61;
        end else begin
            wait_cnt <= xbus.rd ? wait_cnt + 4'h1 : 4'h0;
            ext_rdata <= ~ext_rdata;
        end
    end
endmodule

// ==== program_memory_map_decoder_tb.sv ====
// Self-checking testbench for the program memory map decoder.
`timescale 1ns/1ps
module program_memory_map_decoder_tb;
    typedef struct packed {
        logic [7:0] cfg;
        logic pkg;
        logic [20:0] addr;
        logic [1:0] kind;
        logic [19:0] xaddr;
        logic wide;
        logic wt;
    } pmd_row_t;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic pkg_80pin = 1'b1;
    pmd_pkg::pmd_req_t req = '0;
    pmd_pkg::pmd_rsp_t rsp;
    pmd_pkg::pmd_xbus_t xbus;
    logic req_ready, irq_high = 1'b0, irq_low = 1'b0, vec_load, flash_rd;
    logic [20:0] vec_addr;
    logic [19:0] flash_addr, xa;
    logic [15:0] flash_rdata, ext_rdata, d, e;
    logic ext_ack, sr, err;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rv;
    logic pready, pslverr;
    logic [7:0] cfg_byte = 8'hF8;
    logic [3:0] ack_delay = 4'h0;
    int error_cnt = 0, comparisons = 0, rd_cnt = 0, rd_top = 0;
    pmd_row_t rows [11] = '{
        {8'hF8, 1'b1, 21'h000100, 2'h0, 20'h0, 1'b0, 1'b0},
        {8'hF8, 1'b1, 21'h030000, 2'h1, 20'h0, 1'b0, 1'b0},
        {8'h00, 1'b1, 21'h012346, 2'h0, 20'h0, 1'b0, 1'b0},
        {8'h00, 1'b1, 21'h1ABCDE, 2'h2, 20'hABCDE, 1'b0, 1'b1},
        {8'h20, 1'b1, 21'h023456, 2'h2, 20'h00456, 1'b0, 1'b1},
        {8'h10, 1'b1, 21'h023456, 2'h2, 20'h03456, 1'b0, 1'b1},
        {8'h08, 1'b1, 21'h0A3456, 2'h2, 20'h83456, 1'b0, 1'b1},
        {8'hC0, 1'b1, 21'h1FFFFE, 2'h2, 20'hFFFFE, 1'b1, 1'b0},
        {8'hC0, 1'b0, 21'h030000, 2'h1, 20'h0, 1'b0, 1'b0},
        {8'h00, 1'b1, 21'h01FFF8, 2'h0, 20'h0, 1'b0, 1'b0},
        {8'h08, 1'b1, 21'h020000, 2'h2, 20'h00000, 1'b0, 1'b1}};
    pmd_row_t r;

    always #50 mclk = ~mclk;
    always @(posedge mclk) begin
        if (flash_rd === 1'b1) begin
            rd_cnt++;
            if (flash_addr === 20'h0FFFF) rd_top = 1;
        end
    end

    pmd_top pmd_top_i (.mclk(mclk), .reset_n(reset_n), .pkg_80pin(pkg_80pin),
        .req(req), .rsp(rsp), .req_ready(req_ready), .irq_high(irq_high),
        .irq_low(irq_low), .vec_addr(vec_addr), .vec_load(vec_load),
        .flash_rd(flash_rd), .flash_addr(flash_addr),
        .flash_rdata(flash_rdata), .xbus(xbus), .ext_ack(ext_ack),
        .ext_rdata(ext_rdata), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));
    pmd_mem_model pmd_mem_model_i (.mclk(mclk), .reset_n(reset_n),
        .flash_rd(flash_rd), .flash_addr(flash_addr),
        .flash_rdata(flash_rdata), .xbus(xbus), .ext_ack(ext_ack),
        .ext_rdata(ext_rdata), .cfg_byte(cfg_byte), .ack_delay(ack_delay));

    // ==========================================================
    // Shared tasks
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic finish_test;
        $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic do_reset(input logic [7:0] cfg, input logic pkg);
        int n;
        n = 0;
        reset_n <= 1'b0;
        cfg_byte <= cfg;
        pkg_80pin <= pkg;
        repeat (6) @(posedge mclk);
        rd_cnt = 0;
        rd_top = 0;
        reset_n <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (req_ready !== 1'b1 && n < 50);
        check("load_reads", rd_cnt, 3);
        check("top_word_read", rd_top, 0);
        check("vec_load", vec_load, 1);
        check("vec_reset", vec_addr, pmd_pkg::VEC_RESET);
    endtask
    task automatic fetch(input logic [20:0] a, output logic [15:0] dv,
                         output logic saw, output logic [19:0] xv);
        int n;
        n = 0;
        saw = 1'b0;
        xv = 20'h0;
        req.valid <= 1'b1;
        req.addr <= a;
        do begin
            @(posedge mclk);
            n++;
        end while (req_ready !== 1'b1 && n < 50);
        req.valid <= 1'b0;
        do begin
            @(posedge mclk);
            n++;
            if (xbus.rd === 1'b1) begin
                saw = 1'b1;
                xv = xbus.addr;
            end
        end while (rsp.valid !== 1'b1 && n < 100);
        check("rsp_valid", rsp.valid, 1'b1);
        dv = rsp.data;
    endtask
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] wd, output logic [31:0] rdv,
                       output logic ev);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        check("pready", pready, 1'b1);
        rdv = prdata;
        ev = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic irq_test(input logic h, input logic l,
                            input logic [20:0] v);
        int n;
        n = 0;
        irq_high <= h;
        irq_low <= l;
        @(posedge mclk);
        irq_high <= 1'b0;
        irq_low <= 1'b0;
        do begin
            @(posedge mclk);
            n++;
        end while (vec_load !== 1'b1 && n < 10);
        check("vec_load", vec_load, 1'b1);
        check("vec_addr", vec_addr, v);
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        foreach (rows[i]) begin
            r = rows[i];
            // Vary the bus answer time from prompt to slow
            ack_delay <= 4'(i % 4);
            do_reset(r.cfg, r.pkg);
            check("xbus_en", xbus.en, r.pkg && r.cfg[5:4] != 2'h3);
            if (r.kind == 2'h2 || !r.pkg) begin
                check("wide", xbus.wide, r.wide);
                check("wait_en", xbus.wait_en, r.wt);
            end
            fetch(r.addr, d, sr, xa);
            e = (r.kind == 2'h0) ? (r.addr[16:1] ^ 16'h3C5A) :
                (r.kind == 2'h2) ? (r.xaddr[15:0] ^ 16'h9A61) :
                pmd_pkg::NOP_WORD;
            check("fetch_data", d, e);
            check("bus_used", sr, r.kind == 2'h2);
            if (r.kind == 2'h2) check("ext_addr", xa, r.xaddr);
        end
        do_reset(8'h47, 1'b1);
        apb(1'b0, pmd_pkg::OFS_CFG1, 32'h0, rv, err);
        check("cfg1", rv, 32'h0000C3A6);
        apb(1'b0, pmd_pkg::OFS_CFG2, 32'h0, rv, err);
        check("cfg2", rv, 32'h0000C3A7);
        apb(1'b0, pmd_pkg::OFS_CFG3, 32'h0, rv, err);
        check("cfg3", rv, 32'h00005C47);
        apb(1'b0, pmd_pkg::OFS_EBC, 32'h0, rv, err);
        check("ebc", rv, 32'h00000040);
        apb(1'b0, 12'h100, 32'h0, rv, err);
        check("unmapped_err", err, 1'b1);
        check("unmapped_data", rv, 32'h0);
        apb(1'b1, pmd_pkg::OFS_MEMCTL, 32'h00000020, rv, err);
        apb(1'b0, pmd_pkg::OFS_MEMCTL, 32'h0, rv, err);
        check("memctl", rv, 32'h00000020);
        apb(1'b0, pmd_pkg::OFS_STATUS, 32'h0, rv, err);
        check("status", rv[2:0], 3'h7);
        apb(1'b1, pmd_pkg::OFS_EBC, 32'h0000004F, rv, err);
        apb(1'b1, pmd_pkg::OFS_EBC, 32'h000000FF, rv, err);
        apb(1'b0, pmd_pkg::OFS_EBC, 32'h0, rv, err);
        check("ebc_once", rv, 32'h00000048);
        apb(1'b0, pmd_pkg::OFS_STATUS, 32'h0, rv, err);
        check("lock", rv, 32'h0000000F);
        fetch(21'h040000, d, sr, xa);
        check("wait_cnt", xbus.wait_cnt, 2'h2);
        check("wait_on", xbus.wait_en, 1'b1);
        check("wide_on", xbus.wide, 1'b1);
        fetch(21'h000000, d, sr, xa);
        check("back_to_back", d, 16'h3C5A);
        irq_test(1'b1, 1'b0, pmd_pkg::VEC_HIGH);
        irq_test(1'b0, 1'b1, pmd_pkg::VEC_LOW);
        irq_test(1'b1, 1'b1, pmd_pkg::VEC_HIGH);
        finish_test();
    end
    initial begin
        #(100 * 20000);
        error_cnt++;
        $display("CHECK FAILED watchdog expected done seen hang");
        finish_test();
    end
endmodule
